//--- design/pfb_bridge.sv
// Forwarding core: PCIe request queue to secondary bus, completions back upstream
`timescale 1ns/10ps
`include "pfb_map.svh"
module pfb_bridge import pfb_pkg::*; #(
  parameter int unsigned CFG_TO_CYC = `PFB_CFG_TO_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Requests from the PCIe receive side
  input wire logic up_req_valid,
  input wire pfb_req_t up_req,
  output logic up_req_ready,
  // Completions to the PCIe transmit side
  output logic cpl_valid,
  output pfb_cpl_t cpl,
  input wire logic cpl_ready,
  // Replay acknowledge and completion buffer release
  input wire logic rpl_ack_valid,
  input wire logic [11:0] rpl_ack_bytes,
  input wire logic cbuf_rel_valid,
  input wire logic [11:0] cbuf_rel_bytes,
  // Flow control advertisement and own upstream requester ID
  output logic fc_valid,
  output pfb_fc_t fc,
  output logic [15:0] up_rid,
  // Secondary bus
  input wire logic pci_clk,
  input wire pfb_rsp_t sec_rsp,
  input wire logic [7:0] sec_xfer_bytes,
  output logic sec_req_valid,
  output pfb_sec_req_t sec_req,
  output logic sec_stop
);
  typedef enum logic [1:0] {ST_IDLE, ST_BUS, ST_SPLIT, ST_CPL} pfb_state_t;

  // ****************************************
  // Declarations
  // ****************************************
  logic [2:0] ctrl_q;
  logic [23:0] bus_q;
  logic [7:0] cline_q;
  logic [31:0] pf_base_q, pf_lim_q;
  logic ma_q, crs_st_q;
  logic [31:0] rdata_q;
  logic [2:0] pclk_q;
  pfb_rsp_t rsp1_q, rsp2_q;
  logic [7:0] xb1_q, xb2_q;
  logic pedge, rsp_ev;
  logic [3:0] q_v_q, q_crs_q, q_split_q;
  pfb_req_t q_e_q [`PFB_QDEPTH];
  logic [1:0] head_q, tail_q, sel_q;
  logic [2:0] qcnt;
  pfb_state_t st_q, st_d;
  pfb_req_t cur, e_upd;
  pfb_cmd_t x_cmd;
  logic [7:0] frag;
  logic [7:0] need;
  logic alloc, q_upd, q_free, rotate, issue, cpl_ld, ma_set, split_mark;
  logic [1:0] free_idx, rot_idx;
  pfb_cpl_t cpl_d;
  logic [7:0] give_back, take;
  pfb_cstat_t res_stat_q, res_stat_d;
  logic [7:0] res_bytes_q, res_bytes_d;
  logic res_send_q, res_send_d, res_free_q, res_free_d;
  logic [1:0] res_idx_q;
  logic cpl_pend_q;
  pfb_cpl_t cpl_q;
  logic [11:0] rpl_free_q, cbuf_free_q;
  logic [11:0] cpl_cost;
  logic cpl_go;
  logic [31:0] tmr_q;
  logic tmr_run, tmr_exp, crs_fire;
  logic [15:0] fc_cnt_q;
  pfb_sec_req_t sreq_q;
  logic sreq_v_q;

  // ****************************************
  // Register port
  // ****************************************
  // Control and window registers
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q <= `PFB_CTRL_RST;
      bus_q <= `PFB_BUS_RST;
      cline_q <= `PFB_CLINE_RST;
      pf_base_q <= `PFB_PF_RST;
      pf_lim_q <= `PFB_PF_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `PFB_REG_CTRL: ctrl_q <= reg_wdata[2:0];
        `PFB_REG_BUS: bus_q <= reg_wdata[23:0];
        `PFB_REG_CLINE: cline_q <= reg_wdata[7:0];
        `PFB_REG_PF_BASE: pf_base_q <= reg_wdata;
        `PFB_REG_PF_LIMIT: pf_lim_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Sticky status, write one to clear; a same-cycle event wins
  always_ff @(posedge clk) begin
    if (reset) begin
      ma_q <= 1'b0;
      crs_st_q <= 1'b0;
    end else begin
      if (ma_set) begin
        ma_q <= 1'b1;
      end else if (reg_wr && reg_addr == `PFB_REG_STAT && reg_wdata[`PFB_STAT_MA]) begin
        ma_q <= 1'b0;
      end
      if (crs_fire) begin
        crs_st_q <= 1'b1;
      end else if (reg_wr && reg_addr == `PFB_REG_STAT && reg_wdata[`PFB_STAT_CRS]) begin
        crs_st_q <= 1'b0;
      end
    end
  end

  // Read data one cycle after the strobe; unmapped reads as zero
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= 32'h00000000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `PFB_REG_CTRL: rdata_q <= {29'h0, ctrl_q};
        `PFB_REG_BUS: rdata_q <= {8'h00, bus_q};
        `PFB_REG_CLINE: rdata_q <= {24'h0, cline_q};
        `PFB_REG_PF_BASE: rdata_q <= pf_base_q;
        `PFB_REG_PF_LIMIT: rdata_q <= pf_lim_q;
        `PFB_REG_STAT: rdata_q <= {21'h0, qcnt, 6'h0, crs_st_q, ma_q};
        default: rdata_q <= 32'h00000000;
      endcase
    end else begin
      rdata_q <= 32'h00000000;
    end
  end
  assign reg_rdata = rdata_q;

  // ****************************************
  // Secondary bus sampling
  // ****************************************
  // Two flops per pin, a third stage on the clock for its rising edge
  always_ff @(posedge clk) begin
    if (reset) begin
      pclk_q <= 3'h0;
      rsp1_q <= PFB_R_NONE;
      rsp2_q <= PFB_R_NONE;
      xb1_q <= 8'h00;
      xb2_q <= 8'h00;
    end else begin
      pclk_q <= {pclk_q[1:0], pci_clk};
      rsp1_q <= sec_rsp;
      rsp2_q <= rsp1_q;
      xb1_q <= sec_xfer_bytes;
      xb2_q <= xb1_q;
    end
  end
  assign pedge = pclk_q[1] && !pclk_q[2];
  assign rsp_ev = pedge && (rsp2_q != PFB_R_NONE);

  // ****************************************
  // Request queue
  // ****************************************
  // Entries are filled at the tail; holes left by finished reads are skipped
  assign alloc = up_req_valid && up_req_ready;
  assign up_req_ready = !q_v_q[tail_q];
  always_comb begin
    qcnt = 3'h0;
    for (int i = 0; i < `PFB_QDEPTH; i++) begin
      qcnt = qcnt + {2'b00, q_v_q[i]};
    end
  end

  for (genvar g = 0; g < `PFB_QDEPTH; g++) begin : g_ent
    // One entry: valid, payload, retry-status and split marks
    always_ff @(posedge clk) begin
      if (reset) begin
        q_v_q[g] <= 1'b0;
        q_crs_q[g] <= 1'b0;
        q_split_q[g] <= 1'b0;
        q_e_q[g] <= '0;
      end else if (alloc && tail_q == 2'(g)) begin
        q_v_q[g] <= 1'b1;
        q_crs_q[g] <= 1'b0;
        q_split_q[g] <= 1'b0;
        q_e_q[g] <= up_req;
      end else begin
        if (q_free && free_idx == 2'(g)) begin
          q_v_q[g] <= 1'b0;
        end
        if (crs_fire && sel_q == 2'(g)) begin
          q_crs_q[g] <= 1'b1;
        end
        if (split_mark && sel_q == 2'(g)) begin
          q_split_q[g] <= 1'b1;
        end
        if (q_upd && sel_q == 2'(g)) begin
          q_e_q[g] <= e_upd;
        end
      end
    end
  end

  // Arrival order pointers; selection only leaves the head for another read
  always_ff @(posedge clk) begin
    if (reset) begin
      tail_q <= 2'h0;
      head_q <= 2'h0;
      sel_q <= 2'h0;
    end else begin
      if (alloc) begin
        tail_q <= tail_q + 2'h1;
      end
      if (!q_v_q[head_q] && head_q != tail_q) begin
        head_q <= head_q + 2'h1;
      end
      if (rotate) begin
        sel_q <= rot_idx;
      end else if (st_q == ST_IDLE && !q_v_q[sel_q]) begin
        sel_q <= head_q;
      end
    end
  end

  // Next waiting read after the selected one, else stay put
  always_comb begin
    rot_idx = sel_q;
    for (int k = `PFB_QDEPTH - 1; k > 0; k--) begin
      if (q_v_q[2'(sel_q + 2'(k))] && q_e_q[2'(sel_q + 2'(k))].kind == PFB_K_MRD) begin
        rot_idx = 2'(sel_q + 2'(k));
      end
    end
  end

  // ****************************************
  // Translation and sequencing
  // ****************************************
  assign cur = q_e_q[sel_q];
  pfb_cmd_xlate u_xlate (
    .req(cur),
    .pf_base(pf_base_q),
    .pf_limit(pf_lim_q),
    .cline_dw(cline_q),
    .mwi_en(ctrl_q[`PFB_CTRL_MWI_EN]),
    .cmd(x_cmd),
    .frag(frag)
  );
  // Writes need no completion room, reads and config do
  assign need = (cur.kind == PFB_K_MWR) ? 8'h00 : frag;

  // Transaction sequencer
  always_comb begin
    st_d = st_q;
    issue = 1'b0;
    q_upd = 1'b0;
    q_free = 1'b0;
    free_idx = sel_q;
    rotate = 1'b0;
    e_upd = cur;
    cpl_ld = 1'b0;
    cpl_d = '0;
    ma_set = 1'b0;
    split_mark = 1'b0;
    give_back = 8'h00;
    take = 8'h00;
    res_stat_d = res_stat_q;
    res_bytes_d = res_bytes_q;
    res_send_d = res_send_q;
    res_free_d = res_free_q;
    unique case (st_q)
      ST_IDLE: begin
        if (q_v_q[sel_q] && cur.kind == PFB_K_CFG && cur.ext_reg != 4'h0) begin
          if (!cpl_pend_q) begin
            ma_set = 1'b1;
            cpl_ld = 1'b1;
            cpl_d = '{PFB_S_UR, cur.rid, cur.tag, 8'h00};
            q_free = 1'b1;
          end
        end else if (q_v_q[sel_q] && {4'h0, cbuf_free_q} >= {8'h00, need}) begin
          issue = 1'b1;
          take = need;
          st_d = ST_BUS;
        end
      end
      ST_BUS: begin
        if (rsp_ev) begin
          unique case (rsp2_q)
            PFB_R_DONE, PFB_R_ERR: begin
              if (cur.kind == PFB_K_MWR) begin
                q_free = 1'b1;
                st_d = ST_IDLE;
              end else begin
                res_stat_d = (rsp2_q == PFB_R_ERR) ? PFB_S_CA : PFB_S_SC;
                res_bytes_d = (cur.kind == PFB_K_MRD) ? frag : 8'h00;
                res_send_d = !q_crs_q[sel_q];
                res_free_d = (rsp2_q == PFB_R_ERR) || (cur.len == {5'h00, frag});
                q_upd = 1'b1;
                e_upd.addr = cur.addr + {24'h0, frag};
                e_upd.len = cur.len - {5'h00, frag};
                e_upd.first_be = 4'hf;
                st_d = ST_CPL;
              end
            end
            PFB_R_DISC: begin
              q_upd = 1'b1;
              e_upd.addr = cur.addr + {24'h0, xb2_q};
              e_upd.len = cur.len - {5'h00, xb2_q};
              e_upd.first_be = 4'hf;
              if (cur.kind == PFB_K_MRD) begin
                give_back = need - xb2_q;
                res_stat_d = PFB_S_SC;
                res_bytes_d = xb2_q;
                res_send_d = 1'b1;
                res_free_d = (cur.len == {5'h00, xb2_q});
                st_d = ST_CPL;
              end else begin
                q_upd = (cur.kind == PFB_K_MWR);
                give_back = need;
                st_d = ST_IDLE;
              end
            end
            PFB_R_SPLIT: begin
              split_mark = 1'b1;
              st_d = ST_SPLIT;
            end
            default: begin
              give_back = need;
              rotate = (cur.kind == PFB_K_MRD);
              st_d = ST_IDLE;
            end
          endcase
        end
      end
      ST_SPLIT: begin
        if (rsp_ev && (rsp2_q == PFB_R_SPLITCPL || rsp2_q == PFB_R_ERR)) begin
          res_stat_d = (rsp2_q == PFB_R_ERR) ? PFB_S_CA : PFB_S_SC;
          res_bytes_d = (cur.kind == PFB_K_MRD) ? frag : 8'h00;
          res_send_d = !q_crs_q[sel_q];
          res_free_d = (rsp2_q == PFB_R_ERR) || (cur.len == {5'h00, frag});
          q_upd = 1'b1;
          e_upd.addr = cur.addr + {24'h0, frag};
          e_upd.len = cur.len - {5'h00, frag};
          st_d = ST_CPL;
        end
      end
      ST_CPL: begin
        if (!cpl_pend_q) begin
          cpl_ld = res_send_q;
          cpl_d = '{res_stat_q, cur.rid, cur.tag, res_bytes_q};
          q_free = res_free_q;
          free_idx = res_idx_q;
          rotate = (cur.kind == PFB_K_MRD) && !res_free_q;
          if (!res_send_q) begin
            give_back = res_bytes_q;
          end
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // Sequencer state and the held result of the last bus answer
  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= ST_IDLE;
      res_stat_q <= PFB_S_SC;
      res_bytes_q <= 8'h00;
      res_send_q <= 1'b0;
      res_free_q <= 1'b0;
      res_idx_q <= 2'h0;
    end else begin
      st_q <= st_d;
      res_stat_q <= res_stat_d;
      res_bytes_q <= res_bytes_d;
      res_send_q <= res_send_d;
      res_free_q <= res_free_d;
      if (st_q != ST_CPL) begin
        res_idx_q <= sel_q;
      end
    end
  end

  // Secondary request; held until the bus answers
  always_ff @(posedge clk) begin
    if (reset) begin
      sreq_v_q <= 1'b0;
      sreq_q <= '0;
    end else if (issue) begin
      sreq_v_q <= 1'b1;
      sreq_q.cmd <= x_cmd;
      sreq_q.addr <= cur.addr;
      sreq_q.len <= frag;
      sreq_q.first_be <= cur.first_be;
      sreq_q.last_be <= cur.last_be;
      // Posted writes keep their own ID and tag; others take the bus ID and the entry index in tag bits 1:0
      sreq_q.rid <= (cur.kind == PFB_K_MWR) ? cur.rid : bus_q[15:0];
      sreq_q.tag <= (cur.kind == PFB_K_MWR) ? cur.tag : {6'h00, sel_q};
    end else if (rsp_ev) begin
      sreq_v_q <= 1'b0;
    end
  end
  assign sec_req_valid = sreq_v_q;
  assign sec_req = sreq_q;
  assign sec_stop = (qcnt >= `PFB_QNEAR_FULL) || (cbuf_free_q < {4'h0, `PFB_FRAG_BYTES});
  assign up_rid = {bus_q[15:8], 5'h00, 3'h0};

  // ****************************************
  // Configuration timer
  // ****************************************
  // Runs while a forwarded config waits and no retry status has gone out
  assign tmr_run = q_v_q[sel_q] && cur.kind == PFB_K_CFG && !q_crs_q[sel_q] && st_q != ST_CPL;
  assign tmr_exp = tmr_q >= CFG_TO_CYC - 1;
  assign crs_fire = tmr_run && tmr_exp && ctrl_q[`PFB_CTRL_CRS_EN] && !cpl_pend_q && !cpl_ld;
  always_ff @(posedge clk) begin
    if (reset) begin
      tmr_q <= 32'h0;
    end else if (!tmr_run) begin
      tmr_q <= 32'h0;
    end else if (!tmr_exp) begin
      tmr_q <= tmr_q + 32'h1;
    end
  end

  // ****************************************
  // Completion and replay space
  // ****************************************
  assign cpl_cost = `PFB_CPL_HDR_BYTES + {4'h0, cpl_q.bytes};
  assign cpl_valid = cpl_pend_q && (rpl_free_q >= cpl_cost);
  assign cpl = cpl_q;
  assign cpl_go = cpl_valid && cpl_ready;
  always_ff @(posedge clk) begin
    if (reset) begin
      cpl_pend_q <= 1'b0;
      cpl_q <= '0;
    end else if (crs_fire) begin
      cpl_pend_q <= 1'b1;
      cpl_q <= '{PFB_S_CRS, cur.rid, cur.tag, 8'h00};
    end else if (cpl_ld) begin
      cpl_pend_q <= 1'b1;
      cpl_q <= cpl_d;
    end else if (cpl_go) begin
      cpl_pend_q <= 1'b0;
    end
  end

  // Replay room shrinks as completions leave and grows as they are acknowledged
  always_ff @(posedge clk) begin
    if (reset) begin
      rpl_free_q <= `PFB_REPLAY_BYTES;
    end else begin
      rpl_free_q <= rpl_free_q - (cpl_go ? cpl_cost : 12'h000) + (rpl_ack_valid ? rpl_ack_bytes : 12'h000);
    end
  end

  // Completion room reserved at issue, returned on retry, disconnect, unsent result or upstream release
  always_ff @(posedge clk) begin
    if (reset) begin
      cbuf_free_q <= `PFB_CBUF_BYTES;
    end else begin
      cbuf_free_q <= cbuf_free_q - {4'h0, take} + {4'h0, give_back} +
                     (cbuf_rel_valid ? cbuf_rel_bytes : 12'h000);
    end
  end

  // ****************************************
  // Flow control advertisement
  // ****************************************
  // Free entries and free completion room in 16-byte units, sent periodically
  always_ff @(posedge clk) begin
    if (reset) begin
      fc_cnt_q <= 16'h0;
      fc_valid <= 1'b0;
      fc <= '0;
    end else if (fc_cnt_q == 16'(`PFB_FC_PERIOD_CYC - 1)) begin
      fc_cnt_q <= 16'h0;
      fc_valid <= 1'b1;
      fc.hdr <= 3'(`PFB_QDEPTH) - qcnt;
      fc.data <= cbuf_free_q[11:4];
    end else begin
      fc_cnt_q <= fc_cnt_q + 16'h1;
      fc_valid <= 1'b0;
    end
  end
endmodule

//--- design/pfb_cmd_xlate.sv
// Secondary bus command and fragment length for one queued request
`timescale 1ns/10ps
`include "pfb_map.svh"
module pfb_cmd_xlate import pfb_pkg::*; (
  // Request and window setup
  input wire pfb_req_t req,
  input wire logic [31:0] pf_base,
  input wire logic [31:0] pf_limit,
  input wire logic [7:0] cline_dw,
  input wire logic mwi_en,
  // Translation
  output pfb_cmd_t cmd,
  output logic [7:0] frag
);
  logic [7:0] room;
  logic [9:0] cl;
  logic [9:0] cl_m;
  logic in_pf;
  logic mwi_ok;

  // Room to the next 128-byte boundary bounds every memory fragment
  assign room = `PFB_FRAG_BYTES - {1'b0, req.addr[6:0]};
  assign cl = {cline_dw, 2'b00};
  assign cl_m = cl - 10'h001;
  assign in_pf = (req.addr >= pf_base) && (req.addr <= pf_limit);
  // Whole lines with full byte enables only; a disconnect remainder is rechecked with its first enables set full
  assign mwi_ok = mwi_en && (cl != 10'h000) && ((req.addr[9:0] & cl_m) == 10'h000) &&
                  (({2'b00, frag} & cl_m) == 10'h000) && (req.first_be == 4'hf) &&
                  (req.last_be == 4'hf);

  // Memory fragment length never exceeds what was asked for; a config fragment is always 4 bytes
  always_comb begin
    if (req.kind == PFB_K_CFG) begin
      frag = 8'h04;
    end else if (req.len < {5'h00, room}) begin
      frag = req.len[7:0];
    end else begin
      frag = room;
    end
  end

  // Equal size to the cacheline picks the line read
  always_comb begin
    unique case (req.kind)
      PFB_K_CFG: cmd = PFB_C_CFG;
      PFB_K_MWR: cmd = mwi_ok ? PFB_C_MWI : PFB_C_MW;
      PFB_K_MRD: begin
        if (!in_pf) begin
          cmd = PFB_C_MRD;
        end else if (req.len <= {3'h0, cl}) begin
          cmd = PFB_C_MRL;
        end else begin
          cmd = PFB_C_MRM;
        end
      end
      default: cmd = PFB_C_MRD;
    endcase
  end
endmodule

//--- include/pfb_map.svh
// Constants of the PCIe-to-PCI forwarding bridge core
`ifndef PFB_MAP_SVH
`define PFB_MAP_SVH
// ****************************************
// Register map
// ****************************************
`define PFB_REG_CTRL 8'h00
`define PFB_REG_BUS 8'h04
`define PFB_REG_CLINE 8'h08
`define PFB_REG_PF_BASE 8'h0c
`define PFB_REG_PF_LIMIT 8'h10
`define PFB_REG_STAT 8'h14
`define PFB_CTRL_CRS_EN 0
`define PFB_CTRL_MWI_EN 1
`define PFB_CTRL_PCIX 2
`define PFB_STAT_MA 0
`define PFB_STAT_CRS 1
`define PFB_STAT_QCNT 8
`define PFB_CTRL_RST 3'h0
`define PFB_BUS_RST 24'h000000
`define PFB_CLINE_RST 8'h08
`define PFB_PF_RST 32'h00000000
// ****************************************
// Sizes and timing
// ****************************************
`define PFB_QDEPTH 4
`define PFB_QNEAR_FULL 3'h3
`define PFB_FRAG_BYTES 8'h80
`define PFB_CBUF_BYTES 12'h400
`define PFB_REPLAY_BYTES 12'h800
`define PFB_CPL_HDR_BYTES 12'h010
`define PFB_CLK_MHZ 20
`define PFB_CFG_TO_US 1000
`define PFB_CFG_TO_CYC (`PFB_CFG_TO_US * `PFB_CLK_MHZ)
`define PFB_FC_PERIOD_US 30
`define PFB_FC_PERIOD_CYC (`PFB_FC_PERIOD_US * `PFB_CLK_MHZ)
`endif

//--- include/pfb_pkg.sv
// Types shared by the forwarding bridge core
package pfb_pkg;
  // Kind of request arriving from the PCIe side
  typedef enum logic [1:0] {PFB_K_CFG, PFB_K_MRD, PFB_K_MWR} pfb_kind_t;
  // Secondary bus command; the invalidate form is the block write in PCI-X mode
  typedef enum logic [2:0] {PFB_C_CFG, PFB_C_MRD, PFB_C_MRL, PFB_C_MRM, PFB_C_MW, PFB_C_MWI} pfb_cmd_t;
  // Termination seen on the secondary bus
  typedef enum logic [2:0] {
    PFB_R_NONE, PFB_R_DONE, PFB_R_RETRY, PFB_R_DISC, PFB_R_ERR, PFB_R_SPLIT, PFB_R_SPLITCPL
  } pfb_rsp_t;
  // Completion status sent upstream
  typedef enum logic [1:0] {PFB_S_SC, PFB_S_UR, PFB_S_CRS, PFB_S_CA} pfb_cstat_t;
  typedef struct packed {
    pfb_kind_t kind;
    logic [3:0] ext_reg;
    logic [31:0] addr;
    logic [12:0] len;
    logic [3:0] first_be;
    logic [3:0] last_be;
    logic [15:0] rid;
    logic [7:0] tag;
    logic relaxed;
  } pfb_req_t;
  typedef struct packed {
    pfb_cmd_t cmd;
    logic [31:0] addr;
    logic [7:0] len;
    logic [3:0] first_be;
    logic [3:0] last_be;
    logic [15:0] rid;
    logic [7:0] tag;
  } pfb_sec_req_t;
  typedef struct packed {
    pfb_cstat_t status;
    logic [15:0] rid;
    logic [7:0] tag;
    logic [7:0] bytes;
  } pfb_cpl_t;
  typedef struct packed {
    logic [2:0] hdr;
    logic [7:0] data;
  } pfb_fc_t;
endpackage

//--- tb/pfb_bridge_checker.sv
// Port checker for the forwarding bridge core
`timescale 1ns/10ps
module pfb_bridge_checker import pfb_pkg::*; #(
  parameter int unsigned CFG_TO_CYC = 20000
) (
  // Clock, reset, register read
  input wire logic clk, input wire logic reset, input wire logic reg_rd, input wire logic [31:0] reg_rdata,
  // Traffic
  input wire logic up_req_ready, input wire logic fc_valid, input wire pfb_fc_t fc, input wire logic [15:0] up_rid,
  input wire logic sec_req_valid, input wire pfb_sec_req_t sec_req, input wire logic sec_stop
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [9:0] gap_q;
  logic seen_q;
  // Cycles since the last credit update; 600 is the designer's period
  always_ff @(posedge clk) begin
    gap_q <= (reset || fc_valid) ? 10'h000 : gap_q + 10'h001;
    seen_q <= !reset && (seen_q || fc_valid);
  end
  sequence s_held;
    sec_req_valid ##1 sec_req_valid;
  endsequence
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its slot");
  a_up_rid: assert property (up_rid[7:0] == 8'h00)
    else $error("upstream id device bits");
  a_req_hold: assert property (s_held |-> $stable(sec_req))
    else $error("bus request moved");
  a_frag_bound: assert property (sec_req_valid |-> {1'b0, sec_req.len} + {2'b00, sec_req.addr[6:0]} <= 9'h080)
    else $error("fragment crosses block");
  a_stop_full: assert property (!up_req_ready |-> sec_stop)
    else $error("no stop while full");
  a_fc_period: assert property (fc_valid && seen_q |-> gap_q == 10'd599)
    else $error("credit period");
  a_fc_due: assert property (gap_q <= 10'd600)
    else $error("credit update missing");
  a_fc_range: assert property (fc_valid |-> fc.hdr <= 3'h4 && fc.data <= 8'h40)
    else $error("credits exceed buffers");
endmodule
bind pfb_bridge pfb_bridge_checker #(.CFG_TO_CYC(CFG_TO_CYC)) u_chk (.clk, .reset, .reg_rd, .reg_rdata,
  .up_req_ready, .fc_valid, .fc, .up_rid, .sec_req_valid, .sec_req, .sec_stop);

//--- tb/pfb_bridge_tb_top.sv
// Self-checking bench for the forwarding bridge core
`timescale 1ns/10ps
`include "pfb_map.svh"
module pfb_bridge_tb_top import pfb_pkg::*;;
  logic clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, up_req_valid = 1'b0, cpl_ready = 1'b1, pv = 1'b0;
  logic rpl_ack_valid = 1'b0, cbuf_rel_valid = 1'b0, up_req_ready, cpl_valid, fc_valid, pci_clk, sec_req_valid, sec_stop;
  logic [7:0] reg_addr = 8'h00, sec_xfer_bytes;
  logic [11:0] rpl_ack_bytes = 12'h000, cbuf_rel_bytes = 12'h000;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rdv, a;
  logic [15:0] up_rid;
  pfb_req_t up_req = '0;
  pfb_rsp_t ans = PFB_R_DONE, sec_rsp;
  pfb_cpl_t cpl, c;
  pfb_sec_req_t sec_req, ls, q;
  pfb_fc_t fc;
  int n_errors = 0, total_checks = 0, n_iss = 0, n_cpl = 0, cyc = 0, i, k, m, len, sum;
  pfb_bridge #(.CFG_TO_CYC(40)) uut (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .up_req_valid,
    .up_req, .up_req_ready, .cpl_valid, .cpl, .cpl_ready, .rpl_ack_valid, .rpl_ack_bytes, .cbuf_rel_valid,
    .cbuf_rel_bytes, .fc_valid, .fc, .up_rid, .pci_clk, .sec_rsp, .sec_xfer_bytes, .sec_req_valid, .sec_req, .sec_stop);
  pfb_sec_model far (.answer(ans), .req_valid(sec_req_valid), .pci_clk, .sec_rsp, .sec_xfer_bytes);
  always #25 clk = ~clk;
  // Count bus issues and taken completions; a hang ends the run
  always @(posedge clk) begin
    pv <= sec_req_valid;
    if (sec_req_valid) ls <= sec_req;
    if (sec_req_valid && !pv) n_iss <= n_iss + 1;
    if (cpl_valid && cpl_ready) n_cpl <= n_cpl + 1;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge clk) reg_rd <= 1'b0;
    #1 rdv = reg_rdata;
    @(posedge clk);
  endtask
  task automatic send(input pfb_kind_t kd, input logic [3:0] x, input logic [31:0] ad, input logic [12:0] l);
    up_req <= '{kd, x, ad, l, kd == PFB_K_CFG ? 4'h6 : 4'hf, 4'hf, 16'h0100, 8'h55, 1'b1};
    up_req_valid <= 1'b1;
    #1 while (up_req_ready !== 1'b1) @(posedge clk) #1;
    @(posedge clk) up_req_valid <= 1'b0;
  endtask
  // Take one completion, then hand back its replay and buffer space
  task automatic getcpl(input pfb_cstat_t st, input int b);
    #1 for (m = 0; m < 4000 && cpl_valid !== 1'b1; m++) @(posedge clk) #1;
    c = cpl;
    q = ls;
    cmp("cpl status", st, c.status);
    if (b >= 0) cmp("cpl bytes", b, c.bytes);
    @(posedge clk) rpl_ack_valid <= 1'b1;
    rpl_ack_bytes <= 12'h010 + c.bytes;
    cbuf_rel_valid <= 1'b1;
    cbuf_rel_bytes <= {4'h0, c.bytes};
    @(posedge clk) rpl_ack_valid <= 1'b0;
    cbuf_rel_valid <= 1'b0;
  endtask
  function automatic pfb_cmd_t rcmd(input logic [31:0] ad, input int l);
    if (ad < 32'h1000_0000 || ad > 32'h1fff_ffff) return PFB_C_MRD;
    return l <= 32 ? PFB_C_MRL : PFB_C_MRM;
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence: registers, config screening and retry status, writes, reads
  initial begin
    void'($urandom(32'hf1fc633a));
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(`PFB_REG_CLINE);
    cmp("cacheline", `PFB_CLINE_RST, rdv);
    rd(8'h40);
    cmp("unmapped", 0, rdv);
    wr(`PFB_REG_BUS, 32'h0502);
    wr(`PFB_REG_PF_BASE, 32'h1000_0000);
    wr(`PFB_REG_PF_LIMIT, 32'h1fff_ffff);
    wr(`PFB_REG_CTRL, 32'h3);
    cmp("up rid", 16'h0500, up_rid);
    $display("register test done");
    send(PFB_K_CFG, 4'h3, 32'h0, 13'd4);
    getcpl(PFB_S_UR, -1);
    cmp("issues", 0, n_iss);
    rd(`PFB_REG_STAT);
    cmp("abort flag", 1, rdv[0]);
    ans <= PFB_R_RETRY;
    send(PFB_K_CFG, 4'h0, 32'h0, 13'd4);
    getcpl(PFB_S_CRS, -1);
    i = n_iss;
    k = n_cpl;
    repeat (100) @(posedge clk);
    cmp("reissue", 1, n_iss > i);
    ans <= PFB_R_DONE;
    repeat (100) @(posedge clk);
    cmp("late cpl", k, n_cpl);
    wr(`PFB_REG_CTRL, 32'h2);
    ans <= PFB_R_RETRY;
    send(PFB_K_CFG, 4'h0, 32'h0, 13'd4);
    repeat (200) @(posedge clk);
    cmp("no retry cpl", k, n_cpl);
    ans <= PFB_R_DONE;
    getcpl(PFB_S_SC, -1);
    cmp("cfg enables", 4'h6, q.first_be);
    cmp("down rid", 16'h0502, q.rid);
    ans <= PFB_R_ERR;
    send(PFB_K_CFG, 4'h0, 32'h0, 13'd4);
    getcpl(PFB_S_CA, -1);
    ans <= PFB_R_DONE;
    $display("config test done");
    send(PFB_K_MWR, 4'h0, 32'h1000_0000, 13'd64);
    repeat (60) @(posedge clk);
    cmp("write cmd", PFB_C_MWI, ls.cmd);
    for (i = 0; i < 8; i++) begin
      len = i < 2 ? 16 << (i * 4) : ($urandom % 128 + 1) * 4;
      a = i < 2 ? 32'h1000_0000 : 32'h2000_0000 + ($urandom % 512) * 4;
      send(PFB_K_MRD, 4'h0, a, len[12:0]);
      for (sum = 0; sum < len; sum += k) begin
        k = 128 - (a + sum) % 128;
        if (k > len - sum) k = len - sum;
        getcpl(PFB_S_SC, k);
        cmp("read cmd", rcmd(a, len), q.cmd);
      end
    end
    $display("read test done");
    conclude();
  end
endmodule

//--- tb/pfb_sec_model.sv
// Secondary bus model: free running bus clock, scripted terminations
`timescale 1ns/10ps
module pfb_sec_model import pfb_pkg::*; (
  input wire pfb_rsp_t answer,
  input wire logic req_valid,
  output logic pci_clk,
  output pfb_rsp_t sec_rsp,
  output logic [7:0] sec_xfer_bytes
);
  initial pci_clk = 1'b0;
  initial sec_rsp = PFB_R_NONE;
  initial sec_xfer_bytes = 8'h00;
  always #200 pci_clk = ~pci_clk;
  // Answer for one bus period, then idle one so valid can fall; byte count is noise
  always @(negedge pci_clk) begin
    sec_rsp <= (req_valid && sec_rsp == PFB_R_NONE) ? answer : PFB_R_NONE;
    sec_xfer_bytes <= ~sec_xfer_bytes;
  end
endmodule
